// file: src/dbg_access_ctrl.sv
/*
 Debug port access control: disable bit, lock options, pin pair routing.
 Assumes por_reset asserted with reset at power-on; other resets drive reset only.
*/
`default_nettype none
`include "dbg_access_map.svh"

// Function
// - Debugger link: debugger clock line plus bidirectional data line.
// - Debug port enabled after every power-on reset.
// - Writing 1 to disable bit turns the debug port off.
// - Disable bit clears only on power-on reset; other resets keep it.
// - Reversible lock applies once; never relockable after unlock; power-on reset here clears the used flag and allows it again.
// - Permanent lock: no way back to unlocked; power-on reset here returns it to open.
// - Primary pair pin0 data, pin1 clock, function 1, default.
// - Default pins work after power-on without alternate function setup.
// - Only one pin pair routed to debug port at once.
module dbg_access_ctrl
   import dbg_access_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic por_reset,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [31:0] rdata,
   input wire logic pri_clk_pin,
   input wire logic pri_dat_pin_in,
   output logic pri_dat_pin_out,
   output logic pri_dat_pin_oe,
   input wire logic alt_debug_clock_pin,
   input wire logic alt_debug_data_pin_in,
   output logic alt_debug_data_pin_out,
   output logic alt_debug_data_pin_oe,
   input wire logic dap_dat_out,
   input wire logic dap_dat_oe,
   output logic dap_clk_rise,
   output logic dap_dat_in,
   output logic dap_enable
);
   lock_state_t lock_r;
   logic dis_r;
   logic alt_sel_r;
   logic used_r;
   logic grant;
   logic sel_clk;
   logic sel_dat;
   logic key_ok;
   logic [1:0] pri_clk_sync_r;
   logic [1:0] pri_dat_sync_r;
   logic [1:0] alt_clk_sync_r;
   logic [1:0] alt_dat_sync_r;
   dbg_link_if lnk ();

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   assign key_ok = wdata[`LOCK_KEY_MSB:`LOCK_KEY_LSB] == `LOCK_KEY_VAL;

   always_ff @(posedge clk_sys or posedge por_reset) begin
      if (por_reset) begin
         dis_r <= 1'b0;
      end else if (wr_stb && addr == `SYSCTRL_OFS && wdata[`SYSCTRL_DIS_BIT]) begin
         dis_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         alt_sel_r <= 1'b0;
      end else if (wr_stb && addr == `SYSCTRL_OFS) begin
         alt_sel_r <= wdata[`SYSCTRL_ALT_BIT];
      end
   end

   // Lock state survives every reset but power-on here; nonvolatile storage is outside
   always_ff @(posedge clk_sys or posedge por_reset) begin
      if (por_reset) begin
         lock_r <= LK_OPEN;
         used_r <= 1'b0;
      end else if (wr_stb && addr == `LOCKCTRL_OFS && key_ok) begin
         case (lock_r)
            LK_OPEN: begin
               if (wdata[`LOCK_PERM_BIT]) begin
                  lock_r <= LK_PERM;
               end else if (wdata[`LOCK_ONCE_BIT] && !used_r) begin
                  lock_r <= LK_LOCKED;
                  used_r <= 1'b1;
               end
            end
            LK_LOCKED: begin
               if (wdata[`LOCK_PERM_BIT]) begin
                  lock_r <= LK_PERM;
               end else if (wdata[`LOCK_UNLOCK_BIT]) begin
                  lock_r <= LK_OPEN;
               end
            end
            LK_PERM: begin
               lock_r <= LK_PERM;
            end
            default: begin
               lock_r <= LK_PERM;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rdata <= 32'h0000_0000;
      end else if (rd_stb) begin
         rdata <= 32'h0000_0000;
         case (addr)
            `SYSCTRL_OFS: begin
               rdata[`SYSCTRL_DIS_BIT] <= dis_r;
               rdata[`SYSCTRL_ALT_BIT] <= alt_sel_r;
            end
            `LOCKCTRL_OFS: begin
               rdata[`LOCK_ONCE_BIT] <= lock_r == LK_LOCKED;
               rdata[`LOCK_PERM_BIT] <= lock_r == LK_PERM;
            end
            `STATUS_OFS: begin
               rdata[`ST_ENA_BIT] <= grant;
               rdata[`ST_LOCK_BIT] <= lock_r != LK_OPEN;
               rdata[`ST_USED_BIT] <= used_r;
               rdata[`ST_PERM_BIT] <= lock_r == LK_PERM;
               rdata[`ST_ALT_BIT] <= alt_sel_r;
               rdata[`ST_ACT_BIT] <= lnk.active;
            end
            default: begin
               rdata <= 32'h0000_0000;
            end
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Pin routing and link gating
   // ----------------------------------------
   // Enabled unless disabled or locked
   assign grant = !dis_r && lock_r == LK_OPEN;
   // Pins are asynchronous: two flops before the pair select reads them
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pri_clk_sync_r <= 2'h0;
         pri_dat_sync_r <= 2'h0;
         alt_clk_sync_r <= 2'h0;
         alt_dat_sync_r <= 2'h0;
      end else begin
         pri_clk_sync_r <= {pri_clk_sync_r[0], pri_clk_pin};
         pri_dat_sync_r <= {pri_dat_sync_r[0], pri_dat_pin_in};
         alt_clk_sync_r <= {alt_clk_sync_r[0], alt_debug_clock_pin};
         alt_dat_sync_r <= {alt_dat_sync_r[0], alt_debug_data_pin_in};
      end
   end

   assign sel_clk = alt_sel_r ? alt_clk_sync_r[1] : pri_clk_sync_r[1];
   assign sel_dat = alt_sel_r ? alt_dat_sync_r[1] : pri_dat_sync_r[1];
   assign lnk.allow = grant;

   dbg_link_front u_front (
      .clk_sys(clk_sys),
      .reset(reset),
      .swclk(sel_clk),
      .swdio_in(sel_dat),
      .lnk(lnk.front)
   );

   // Gated link toward the debug core
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         dap_clk_rise <= 1'b0;
         dap_dat_in <= 1'b0;
         dap_enable <= 1'b0;
      end else begin
         dap_clk_rise <= lnk.clk_rise && grant;
         dap_dat_in <= lnk.data_in && grant;
         dap_enable <= grant;
      end
   end

   // Primary pins drive with no function setup; alternate pins drive only when selected
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pri_dat_pin_out <= 1'b0;
         pri_dat_pin_oe <= 1'b0;
         alt_debug_data_pin_out <= 1'b0;
         alt_debug_data_pin_oe <= 1'b0;
      end else begin
         pri_dat_pin_out <= dap_dat_out;
         pri_dat_pin_oe <= dap_dat_oe && grant && !alt_sel_r;
         alt_debug_data_pin_out <= dap_dat_out;
         alt_debug_data_pin_oe <= dap_dat_oe && grant && alt_sel_r;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_perm_stays: assert property (@(posedge clk_sys) disable iff (por_reset)
      $past(lock_r) == LK_PERM |-> lock_r == LK_PERM) else $error("perm lock left");
   a_no_relock: assert property (@(posedge clk_sys) disable iff (por_reset)
      $past(lock_r) == LK_OPEN && $past(used_r) |-> lock_r != LK_LOCKED)
      else $error("relock after unlock");
   a_dis_sticky: assert property (@(posedge clk_sys) disable iff (por_reset)
      $past(dis_r) |-> dis_r) else $error("disable bit cleared");
   a_dis_sets: assert property (@(posedge clk_sys) disable iff (por_reset)
      wr_stb && addr == `SYSCTRL_OFS && wdata[`SYSCTRL_DIS_BIT] |=> dis_r && !grant)
      else $error("disable write ignored");
   a_gate_rise: assert property (@(posedge clk_sys) disable iff (reset)
      !grant |=> !dap_clk_rise) else $error("edge passed while blocked");
   a_one_pair: assert property (@(posedge clk_sys) disable iff (reset)
      !(pri_dat_pin_oe && alt_debug_data_pin_oe)) else $error("both pairs drive");
   a_ena_follow: assert property (@(posedge clk_sys) disable iff (reset)
      !reset |=> dap_enable == $past(grant)) else $error("enable lags wrong");
   a_rise_path: assert property (@(posedge clk_sys) disable iff (reset)
      grant && lnk.clk_rise ##1 grant |-> dap_clk_rise) else $error("edge lost");
   a_primary_oe: assert property (@(posedge clk_sys) disable iff (reset)
      grant && !alt_sel_r && dap_dat_oe ##1 grant && !alt_sel_r |-> pri_dat_pin_oe)
      else $error("primary not driven");
endmodule // dbg_access_ctrl
`default_nettype wire

// file: src/dbg_access_map.svh
/*
 Register offsets, field positions, lock key and link idle count for the debug access control block.
 Assumes inclusion by bare name from design and bench files.
*/
`ifndef DBG_ACCESS_MAP_SVH
`define DBG_ACCESS_MAP_SVH
`define SYSCTRL_OFS 4'h0
`define LOCKCTRL_OFS 4'h4
`define STATUS_OFS 4'h8
`define SYSCTRL_DIS_BIT 0
`define SYSCTRL_ALT_BIT 1
`define LOCK_ONCE_BIT 0
`define LOCK_UNLOCK_BIT 1
`define LOCK_PERM_BIT 2
`define LOCK_KEY_MSB 15
`define LOCK_KEY_LSB 8
`define LOCK_KEY_VAL 8'hA5
`define ST_ENA_BIT 0
`define ST_LOCK_BIT 1
`define ST_USED_BIT 2
`define ST_PERM_BIT 3
`define ST_ALT_BIT 4
`define ST_ACT_BIT 5
`define LINK_IDLE_CNT 6'h3F
`endif

// file: src/dbg_access_pkg.sv
/*
 Types shared by the debug access control modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package dbg_access_pkg;
   typedef enum logic [2:0] {
      LK_OPEN = 3'h1,
      LK_LOCKED = 3'h2,
      LK_PERM = 3'h4
   } lock_state_t;
endpackage
`default_nettype wire

// file: src/dbg_link_if.sv
/*
 Interface between the access controller and the link front end.
 Assumes both ends run on clk_sys.
*/
`default_nettype none
interface dbg_link_if;
   logic allow;
   logic clk_rise;
   logic data_in;
   logic active;
   modport ctrl (output allow, input clk_rise, input data_in, input active);
   modport front (input allow, output clk_rise, output data_in, output active);
endinterface
`default_nettype wire

// file: src/dbg_link_front.sv
/*
 Samples a debugger link clock and data pin pair, finds clock rising edges.
 Assumes pins are asynchronous to clk_sys; clk well below clk_sys/4.
*/
`default_nettype none
`include "dbg_access_map.svh"
module dbg_link_front (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic swclk,
   input wire logic swdio_in,
   dbg_link_if.front lnk
);
   logic [1:0] clk_sync_r;
   logic [1:0] dat_sync_r;
   logic clk_prev_r;
   logic [5:0] idle_cnt_r;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         clk_sync_r <= 2'h0;
         dat_sync_r <= 2'h0;
      end else begin
         clk_sync_r <= {clk_sync_r[0], swclk};
         dat_sync_r <= {dat_sync_r[0], swdio_in};
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         clk_prev_r <= 1'b0;
      end else begin
         clk_prev_r <= clk_sync_r[1];
      end
   end

   // Activity lasts a while after the last clock edge seen while allowed
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         idle_cnt_r <= 6'h00;
      end else if (lnk.clk_rise && lnk.allow) begin
         idle_cnt_r <= `LINK_IDLE_CNT;
      end else if (idle_cnt_r != 6'h00) begin
         idle_cnt_r <= idle_cnt_r - 6'h01;
      end
   end

   assign lnk.clk_rise = clk_sync_r[1] & ~clk_prev_r;
   assign lnk.data_in = dat_sync_r[1];
   assign lnk.active = idle_cnt_r != 6'h00;
endmodule // dbg_link_front
`default_nettype wire

// file: tb/dbg_probe.sv
/*
 Debugger probe model: drives the link clock and data line in frames.
 Assumes the bench routes its two lines to one debug pin pair.
*/
`default_nettype none
module dbg_probe (
   output logic swclk,
   output logic dio
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_r;
   initial begin
      swclk = 1'b0;
      dio = 1'b1;
      last_r = 1'b0;
   end
   // clock and data frames
   // Clock stands low between frames; 64 ns period, LSB first
   task automatic frame(input logic [7:0] val);
      #5;
      for (int i = 0; i < 8; i++) begin
         dio = val[i];
         last_r = val[i];
         #32 swclk = 1'b1;
         #32 swclk = 1'b0;
      end
      // Released line shows no stale bit
      dio = ~last_r;
   endtask
endmodule // dbg_probe
`default_nettype wire

// file: tb/testbench.sv
/*
 Self-checking bench for the debug access controller.
 Assumes the design's map header and the probe model.
*/
`default_nettype none
`include "dbg_access_map.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, reset, por_reset, wr_stb, rd_stb, on_alt, dap_dat_out, dap_dat_oe;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, v;
   logic pri_dat_pin_out, pri_dat_pin_oe, alt_debug_data_pin_out, alt_debug_data_pin_oe;
   logic dap_clk_rise, dap_dat_in, dap_enable, swclk, dio, pri_in, alt_in;
   logic [7:0] sh;
   int rises, bad_count, cmp_count;
   localparam logic [31:0] KEY = {16'h0000, `LOCK_KEY_VAL, 8'h00};
   assign pri_in = pri_dat_pin_oe ? pri_dat_pin_out : (on_alt ? 1'b1 : dio);
   assign alt_in = alt_debug_data_pin_oe ? alt_debug_data_pin_out : (on_alt ? dio : 1'b1);
   dbg_probe probe (.swclk(swclk), .dio(dio));
   dbg_access_ctrl dut (.clk_sys(clk_sys), .reset(reset), .por_reset(por_reset),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .pri_clk_pin(on_alt ? 1'b0 : swclk), .pri_dat_pin_in(pri_in),
      .pri_dat_pin_out(pri_dat_pin_out), .pri_dat_pin_oe(pri_dat_pin_oe),
      .alt_debug_clock_pin(on_alt ? swclk : 1'b0), .alt_debug_data_pin_in(alt_in),
      .alt_debug_data_pin_out(alt_debug_data_pin_out),
      .alt_debug_data_pin_oe(alt_debug_data_pin_oe), .dap_dat_out(dap_dat_out),
      .dap_dat_oe(dap_dat_oe), .dap_clk_rise(dap_clk_rise), .dap_dat_in(dap_dat_in),
      .dap_enable(dap_enable));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Sampled mid-cycle so the registered pulse has settled
   always @(negedge clk_sys) begin
      if (dap_clk_rise === 1'b1) begin
         rises++;
         sh = {dap_dat_in, sh[7:1]};
      end
   end
   task automatic end_sim;
      if (bad_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      #1 v = rdata;
   endtask
   // Status bits under a mask, plus the grant level
   task automatic st(input logic [31:0] exp, input logic [31:0] m);
      rd(`STATUS_OFS);
      check(v & m, exp);
      check({31'h0, dap_enable}, {31'h0, exp[`ST_ENA_BIT]});
   endtask
   task automatic link(input logic [7:0] val, input logic grant);
      rises = 0;
      probe.frame(val);
      repeat (8) @(posedge clk_sys);
      check(rises, grant ? 32'h8 : 32'h0);
      if (grant)
         check({24'h0, sh}, {24'h0, val});
   endtask
   task automatic full_reset;
      @(posedge clk_sys);
      reset <= 1'b1;
      por_reset <= 1'b1;
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      por_reset <= 1'b0;
   endtask
   task automatic t_por;
      st(32'h01, 32'h1F);
      rd(`SYSCTRL_OFS);
      check(v, 32'h0);
      link(8'hA5, 1'b1);
      st(32'h21, 32'h3F);
      // Activity flag must time out once the link goes quiet
      repeat (70) @(posedge clk_sys);
      st(32'h01, 32'h3F);
      rd(4'hC);
      check(v, 32'h0);
   endtask
   task automatic t_alt;
      on_alt <= 1'b1;
      wr(`SYSCTRL_OFS, 32'h2);
      st(32'h11, 32'h1F);
      link(8'h3C, 1'b1);
      on_alt <= 1'b0;
      link(8'h5A, 1'b0);
      wr(`SYSCTRL_OFS, 32'h0);
   endtask
   task automatic t_pins;
      // Core drives data; only the selected pair may enable its driver
      dap_dat_out <= 1'b1;
      dap_dat_oe <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 check({30'h0, pri_dat_pin_oe, alt_debug_data_pin_oe}, 32'h2);
      check({31'h0, pri_dat_pin_out}, 32'h1);
      @(posedge clk_sys);
      on_alt <= 1'b1;
      wr(`SYSCTRL_OFS, 32'h2);
      #1 check({30'h0, pri_dat_pin_oe, alt_debug_data_pin_oe}, 32'h1);
      check({31'h0, alt_debug_data_pin_out}, 32'h1);
      @(posedge clk_sys);
      on_alt <= 1'b0;
      wr(`SYSCTRL_OFS, 32'h0);
      dap_dat_oe <= 1'b0;
      dap_dat_out <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 check({30'h0, pri_dat_pin_oe, alt_debug_data_pin_oe}, 32'h0);
   endtask
   task automatic t_lock;
      wr(`LOCKCTRL_OFS, 32'h1);
      st(32'h01, 32'h07);
      wr(`LOCKCTRL_OFS, KEY | 32'h1);
      st(32'h06, 32'h07);
      rd(`LOCKCTRL_OFS);
      check(v, 32'h1);
      link(8'hC3, 1'b0);
      wr(`LOCKCTRL_OFS, KEY | 32'h2);
      st(32'h05, 32'h07);
      wr(`LOCKCTRL_OFS, KEY | 32'h1);
      st(32'h05, 32'h07);
   endtask
   task automatic t_dis;
      wr(`SYSCTRL_OFS, 32'h1);
      st(32'h04, 32'h07);
      link(8'h96, 1'b0);
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      st(32'h04, 32'h07);
      full_reset();
      st(32'h01, 32'h07);
   endtask
   task automatic t_perm;
      wr(`LOCKCTRL_OFS, KEY | 32'h4);
      st(32'h08, 32'h09);
      rd(`LOCKCTRL_OFS);
      check(v, 32'h4);
      wr(`LOCKCTRL_OFS, KEY | 32'h2);
      st(32'h08, 32'h09);
      link(8'h69, 1'b0);
   endtask
   initial begin
      {reset, por_reset} = 2'b11;
      {wr_stb, rd_stb, on_alt, dap_dat_out, dap_dat_oe} = 5'h00;
      addr = 4'h0;
      wdata = 32'h0;
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      por_reset <= 1'b0;
      t_por();
      t_alt();
      t_pins();
      t_lock();
      t_dis();
      t_perm();
      end_sim();
   end
   initial begin
      #200000;
      bad_count++;
      end_sim();
   end
endmodule // testbench
`default_nettype wire
